// [hdl/conditional_branch_decode.sv]
// decode and execute of the two conditional relative branches
// Operation
// [RQ1] opcode e6xx is branch_when_negative; taken only when negative flag is one
// [RQ2] opcode e3xx is branch_when_no_carry; taken only when carry flag is zero
// [RQ3] taken target is instruction address plus two plus twice signed offset
// [RQ4] offset byte is two's complement, -128 to 127 words
// [RQ5] one instruction cycle when not taken, two when taken
// [RQ6] taken: decode, read, process, write pc; then four no-op phases
// [RQ7] not taken: continue at instruction address plus two
// [RQ8] flags stay unchanged by either branch
`timescale 1ns/1ps
`default_nettype none
`include "branch_decode_regs.svh"
module conditional_branch_decode
   import branch_decode_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // instruction presented at q1 of each instruction cycle
   input wire fetch_t fetch,
   input wire flags_t flags_in,
   // program counter and flag results
   output logic [20:0] pc_r,
   output logic pc_load_r,
   output flags_t flags_r,
   output logic busy_r,
   output logic taken_r,
   output phase_t phase_r
);
   // latched word and address, offset byte and computed target
   logic [15:0] ir_r;
   logic [20:0] ia_r;
   logic is_neg, is_nc, cond, nop_cycle_r;
   logic [7:0] off_r;
   logic [20:0] tgt_r;

   // opcode match on the latched word
   assign is_neg = ir_r[15:12] == `OPC_HI_BRANCH && ir_r[11:8] == `OPC_LO_NEG; // [RQ1]
   assign is_nc = ir_r[15:12] == `OPC_HI_BRANCH && ir_r[11:8] == `OPC_LO_NO_CARRY; // [RQ2]
   assign cond = (is_neg && flags_r.negative) || (is_nc && !flags_r.carry); // [RQ1] [RQ2]

   // four phase sequencer, free running
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phase_r <= PH_Q1;
      end else begin
         unique case (phase_r)
            PH_Q1: phase_r <= PH_Q2;
            PH_Q2: phase_r <= PH_Q3;
            PH_Q3: phase_r <= PH_Q4;
            PH_Q4: phase_r <= PH_Q1;
         endcase
      end
   end

   // q1 decode: capture address always, and the word only when valid and not flushing
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ir_r <= 16'h0000;
         ia_r <= 21'h000000;
      end else if (phase_r == PH_Q1) begin
         ir_r <= (fetch.valid && !nop_cycle_r) ? fetch.word : 16'h0000;
         ia_r <= fetch.addr;
      end
   end

   // q2 read offset, q3 compute target
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         off_r <= 8'h00;
         tgt_r <= 21'h000000;
      end else if (phase_r == PH_Q2) begin
         off_r <= ir_r[7:0];
      end else if (phase_r == PH_Q3) begin
         // sign extend, then double for word steps
         tgt_r <= ia_r + `PC_STEP + {{12{off_r[7]}}, off_r, 1'b0}; // [RQ3] [RQ4]
      end
   end

   // q4 write pc, or fall through; taken arms a nop cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pc_r <= 21'h000000;
         pc_load_r <= 1'b0;
         taken_r <= 1'b0;
         nop_cycle_r <= 1'b0;
      end else begin
         pc_load_r <= 1'b0;
         if (phase_r == PH_Q4) begin
            taken_r <= 1'b0;
            nop_cycle_r <= 1'b0;
            if (!nop_cycle_r && cond) begin
               pc_r <= tgt_r; // [RQ6]
               pc_load_r <= 1'b1;
               taken_r <= 1'b1;
               nop_cycle_r <= 1'b1; // [RQ5]
            end else if (!nop_cycle_r) begin
               pc_r <= ia_r + `PC_STEP; // [RQ7]
            end
         end
      end
   end

   // busy through the flushed second cycle
   // lags nop_cycle_r by one clock, so it reads as a plain status level
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= nop_cycle_r; // [RQ5]
      end
   end

   // flags pass through; branches never write them
   // cond reads the copy taken with the word, so a late flag change
   // cannot flip a branch that is already in flight
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flags_r <= '0;
      end else if (phase_r == PH_Q1) begin
         flags_r <= flags_in; // [RQ8]
      end
   end

   // taken branch writes pc once, then stays quiet through its flush
   taken_load_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ6]
      $rose(taken_r) |-> pc_load_r ##1 !pc_load_r[*3])
      else $error("taken branch did not load pc once");

   load_pulse_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ6]
      pc_load_r |=> !pc_load_r)
      else $error("pc load pulse longer than one clock");

   no_load_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ1]
      pc_load_r |-> taken_r)
      else $error("pc loaded without taken branch");

   // taken level stands for one whole instruction cycle
   taken_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ5]
      $rose(taken_r) |-> taken_r[*4] ##1 !taken_r)
      else $error("taken level not four clocks long");

   // a not-taken branch does nothing in q4 beyond the sequential step
   seq_pc_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ7]
      (phase_r == PH_Q4 && !nop_cycle_r && !cond) |=> pc_r == $past(ia_r) + `PC_STEP)
      else $error("fall through pc wrong");

   quiet_q4_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ6]
      (phase_r == PH_Q4 && !cond) |=> !taken_r && !pc_load_r)
      else $error("not taken branch acted in q4");

   // the pc only moves on a q4 edge; other phases leave it alone
   pc_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ6]
      phase_r != PH_Q4 |=> $stable(pc_r))
      else $error("pc moved outside q4");

   // flush: the word after a taken branch never reaches execution
   flush_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ5]
      (phase_r == PH_Q4 && taken_r) |-> ##1 ir_r == 16'h0000)
      else $error("second cycle not flushed");

   flush_no_load_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ5]
      (phase_r == PH_Q4 && nop_cycle_r) |=> !pc_load_r && !taken_r)
      else $error("flushed cycle wrote the pc");

   busy_len_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ5]
      $rose(busy_r) |-> busy_r[*4] ##1 !busy_r)
      else $error("busy not one instruction cycle long");

   // target arithmetic, checked against the captured address as it stood two clocks back
   target_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ3]
      pc_load_r |-> pc_r == $past(ia_r, 2) + `PC_STEP + {{12{off_r[7]}}, off_r, 1'b0})
      else $error("branch target wrong");

   offset_read_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ4]
      phase_r == PH_Q3 |-> off_r == ir_r[7:0])
      else $error("offset byte not read in q2");

   addr_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ3]
      phase_r != PH_Q1 |=> $stable(ia_r))
      else $error("instruction address moved mid cycle");

   // each opcode obeys only its own flag
   neg_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ1]
      (phase_r == PH_Q4 && is_neg && !nop_cycle_r && !flags_r.negative) |=> !pc_load_r)
      else $error("negative branch taken with flag clear");

   neg_take_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ1]
      (phase_r == PH_Q4 && is_neg && !nop_cycle_r && flags_r.negative) |=> pc_load_r)
      else $error("negative branch not taken");

   nc_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ2]
      (phase_r == PH_Q4 && is_nc && !nop_cycle_r && !flags_r.carry) |=> pc_load_r)
      else $error("no carry branch not taken");

   nc_refuse_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ2]
      (phase_r == PH_Q4 && is_nc && !nop_cycle_r && flags_r.carry) |=> !pc_load_r)
      else $error("no carry branch taken with carry set");

   // flags only change on the q1 capture edge
   flags_keep_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ8]
      phase_r != PH_Q1 |=> flags_r == $past(flags_r))
      else $error("flags changed outside sampling");

   // phase sequencer walks the gray order without skipping
   phase_q1_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ6]
      phase_r == PH_Q1 |=> phase_r == PH_Q2)
      else $error("phase did not leave q1 for q2");

   phase_q4_a: assert property (@(posedge sys_clk) disable iff (srst) // [RQ6]
      phase_r == PH_Q4 |=> phase_r == PH_Q1)
      else $error("phase did not wrap from q4");

   // main scenarios
   cov_neg_taken: cover property (@(posedge sys_clk) is_neg && pc_load_r);
   cov_nc_taken: cover property (@(posedge sys_clk) is_nc && pc_load_r);
   cov_back: cover property (@(posedge sys_clk) pc_load_r && off_r[7]);
   cov_not_taken: cover property (@(posedge sys_clk) phase_r == PH_Q4 && is_nc && !cond);
   cov_flush: cover property (@(posedge sys_clk) busy_r && phase_r == PH_Q4);
endmodule
`default_nettype wire

// [hdl/branch_decode_regs.svh]
// constants for the conditional branch decode block
`ifndef BRANCH_DECODE_REGS_SVH
`define BRANCH_DECODE_REGS_SVH
`define OPC_HI_BRANCH 4'he
`define OPC_LO_NEG 4'h6
`define OPC_LO_NO_CARRY 4'h3
`define PC_STEP 21'h000002
`define PC_W 21
`endif

// [hdl/branch_decode_pkg.sv]
// types for the conditional branch decode block
package branch_decode_pkg;
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b11,
      PH_Q4 = 2'b10
   } phase_t;
   typedef struct packed {
      logic negative;
      logic carry;
   } flags_t;
   typedef struct packed {
      logic valid;
      logic [15:0] word;
      logic [20:0] addr;
   } fetch_t;
endpackage

// [sim/tb_conditional_branch_decode.sv]
// self-checking bench for the conditional branch decode block
`timescale 1ns/1ps
`default_nettype none
module tb_conditional_branch_decode;
   import branch_decode_pkg::*;
   logic sys_clk, srst, pc_load_r, busy_r, taken_r;
   fetch_t fetch;
   flags_t flags_in, flags_r;
   logic [20:0] pc_r;
   phase_t phase_r;
   int num_errors = 0;
   int num_checks = 0;
   conditional_branch_decode dut (.sys_clk(sys_clk), .srst(srst), .fetch(fetch),
      .flags_in(flags_in), .pc_r(pc_r), .pc_load_r(pc_load_r), .flags_r(flags_r),
      .busy_r(busy_r), .taken_r(taken_r), .phase_r(phase_r));
   // 40 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // counts, verdict and end of run
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // compare one value
   task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // drive a word for the next q1, judge just after its q4 edge
   task automatic run(input logic [15:0] w, input logic [20:0] ia, input flags_t f,
      input logic ld);
      logic [20:0] exp;
      int n;
      n = 0;
      exp = ia + 21'h000002 + (ld ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h0);
      // bounded wait: a stuck phase counter must not hang the run
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (phase_r !== PH_Q4 && n < 8);
      if (n >= 8) begin
         num_errors++;
         give_verdict();
      end
      @(posedge sys_clk);
      fetch <= '{valid: 1'b1, word: w, addr: ia};
      flags_in <= f;
      repeat (4) @(posedge sys_clk);
      #1;
      check("pc", pc_r, exp);
      check("load", 21'(pc_load_r), 21'(ld));
      check("taken", 21'(taken_r), 21'(ld));
      check("flags", 21'(flags_r), 21'(f));
      check("phase", 21'(phase_r), 21'(PH_Q1));
   endtask
   // negative branch: taken with offsets 5 and -128, then refused at offset 127
   task automatic t_negative();
      run(16'he605, 21'h000100, 2'b10, 1'b1);
      run(16'he680, 21'h001000, 2'b11, 1'b1);
      run(16'he67f, 21'h000200, 2'b01, 1'b0);
      $display("test negative done");
   endtask
   // no-carry branch: taken, refused, wrap at top of space
   task automatic t_no_carry();
      run(16'he37f, 21'h000200, 2'b00, 1'b1);
      run(16'he3ff, 21'h000300, 2'b11, 1'b0);
      run(16'he3ff, 21'h1ffffe, 2'b10, 1'b1);
      $display("test no_carry done");
   endtask
   // word held back to back after a taken branch falls in the flush slot
   task automatic t_flush();
      run(16'he6fe, 21'h000400, 2'b11, 1'b1);
      repeat (2) @(posedge sys_clk);
      #1;
      check("busy", 21'(busy_r), 21'h1);
      repeat (2) @(posedge sys_clk);
      #1;
      check("flush load", 21'(pc_load_r), 21'h0);
      check("flush pc", pc_r, 21'h0003fe);
      $display("test flush done");
   endtask
   // reset, then scenarios
   initial begin
      srst = 1'b1;
      fetch = '0;
      flags_in = '0;
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      t_negative();
      t_no_carry();
      t_flush();
      give_verdict();
   end
endmodule
`default_nettype wire
